// >>> inc/sw_event_pkg.sv
// Functional notes
// [R1] Each masked status bit equals its raw flag ANDed with its enable bit.
// [R2] Clearing a raw flag also clears its masked status bit automatically.
// [R3] Any masked status bit at 1 drives the interrupt request active.
// [R4] Interrupt request is the OR of software and hardware unmasked status.
// [R5] An event with its enable bit at 0 still sets its raw flag.
// [R6] A disabled event sets no masked status bit and no interrupt request.
// [R7] Enable bits: 0 disabled, 1 enabled; all are 0 after reset.
// [R8] Host enables only the sources it uses; unused enables stay 0.
// [R9] Status bit 5 shows antenna receive complete, when enabled.
// [R10] Status bit 4 shows antenna transmit complete, when enabled.
// [R11] Status bit 3 shows the 100 ms antenna receive timeout, when enabled.
// [R12] Status bit 1 shows tuner error: no response or unexpected not-acknowledge.
// [R13] Status bit 0 shows tuner transfer done; never set if errors occurred.
// [R14] Bits 7:6 and 2 of status and enable are reserved, no function.
// [R15] Host writes 1 to the clear register to clear raw and status bits.
// [R16] Clear register bits return to 0 automatically after taking effect.
// [R17] With all unmasked interrupts cleared, interrupt request goes inactive.
// [R18] Receive complete only after a full 10-bit word; short word raises timeout.
// [R19] Interrupt request polarity is a parameter, active high by default.
package sw_event_pkg;

	// Register offsets on the parallel register port.
	localparam logic [7:0] RAW_STATUS_OFS = 8'hF9;
	localparam logic [7:0] MASKED_STATUS_OFS = 8'hFB;
	localparam logic [7:0] ENABLE_OFS = 8'hFD;
	localparam logic [7:0] CLEAR_OFS = 8'hFF;

	// Field positions of the five events.
	localparam int ANT_RX_COMPLETE_BIT = 5;
	localparam int ANT_TX_COMPLETE_BIT = 4;
	localparam int ANT_RX_TIMEOUT_BIT = 3;
	localparam int TUNER_XFER_ERROR_BIT = 1;
	localparam int TUNER_XFER_DONE_BIT = 0;

	// Bits that carry an event; the others are reserved.
	localparam logic [7:0] EVENT_BITS = 8'h3B;

	// Values after reset.
	localparam logic [7:0] ENABLE_RESET = 8'h00;
	localparam logic [7:0] FLAGS_RESET = 8'h00;

	// Length of a complete antenna reply word in bits.
	localparam int RX_WORD_BITS_DEF = 10;

	// Antenna receive timeout, counted by the antenna engine.
	localparam int RX_TIMEOUT_MS = 100;

endpackage

// >>> rtl/sw_event_irq.sv
`timescale 1ns/1ps
module sw_event_irq
	import sw_event_pkg::*;
#(
	parameter int   RX_WORD_BITS    = RX_WORD_BITS_DEF,
	parameter bit   IRQ_ACTIVE_HIGH = 1'b1
) (
	input  wire logic       CORE_CLK,
	input  wire logic       RESET,
	input  wire logic [7:0] REG_ADDR,
	input  wire logic       REG_WR,
	input  wire logic [7:0] REG_WDATA,
	input  wire logic       REG_RD,
	output logic      [7:0] REG_RDATA,
	input  wire logic       ANT_RX_END,
	input  wire logic [3:0] ANT_RX_BIT_COUNT,
	input  wire logic       ANT_RX_NO_REPLY,
	input  wire logic       ANT_TX_END,
	input  wire logic       TUNER_XFER_END,
	input  wire logic       TUNER_XFER_FAIL,
	input  wire logic       HW_IRQ_PENDING,
	output logic            HOST_IRQ_OUT,
	output logic      [7:0] MASKED_STATUS
);

	////////////////////////////////////////////////////////////////////////
	// Parameter checks.
	if (RX_WORD_BITS < 1 || RX_WORD_BITS > 15) begin : g_bad_bits
		$error("RX_WORD_BITS must fit the 4-bit receive count.");
	end

	logic [7:0] raw_q;
	logic [7:0] raw_d;
	logic [7:0] en_q;
	logic [7:0] en_d;
	logic [7:0] clr_q;
	logic [7:0] status_q;
	logic [7:0] status_d;
	logic [7:0] events;
	logic [7:0] clr_now;
	logic       rx_full;

	////////////////////////////////////////////////////////////////////////
	// Event decode from the antenna and tuner engines.

	// A receive that ends short of a full word counts as a timeout.
	assign rx_full = ANT_RX_BIT_COUNT == 4'(RX_WORD_BITS); // R18

	always_comb begin
		events = 8'h00;
		events[ANT_RX_COMPLETE_BIT] = ANT_RX_END && rx_full; // R9 R18
		events[ANT_TX_COMPLETE_BIT] = ANT_TX_END; // R10
		events[ANT_RX_TIMEOUT_BIT] = ANT_RX_NO_REPLY ||
			(ANT_RX_END && !rx_full); // R11 R18
		events[TUNER_XFER_ERROR_BIT] = TUNER_XFER_END && TUNER_XFER_FAIL; // R12
		events[TUNER_XFER_DONE_BIT] = TUNER_XFER_END && !TUNER_XFER_FAIL; // R13
	end

	// Clear bits act in the cycle of the write, so no event slips by.
	assign clr_now = (REG_WR && REG_ADDR == CLEAR_OFS) ?
		(REG_WDATA & EVENT_BITS) : 8'h00; // R15

	// An event in the clearing cycle wins over the clear.
	assign raw_d = ((raw_q & ~clr_now) | events) & EVENT_BITS; // R2 R5

	////////////////////////////////////////////////////////////////////////
	// Raw flags; set regardless of the enable bits.
	always_ff @(posedge CORE_CLK or posedge RESET) begin
		if (RESET) begin
			raw_q <= FLAGS_RESET;
		end else begin
			raw_q <= raw_d; // R5
		end
	end

	// Next enable value. Status looks at it too, so a mask write that
	// meets an event in one cycle still gives raw AND enable.
	assign en_d = (REG_WR && REG_ADDR == ENABLE_OFS) ? REG_WDATA : en_q;

	// Enable register; reserved bits store but steer nothing.
	always_ff @(posedge CORE_CLK or posedge RESET) begin
		if (RESET) begin
			en_q <= ENABLE_RESET; // R7
		end else begin
			en_q <= en_d; // R7
		end
	end

	// Clear register holds the written event bits for one cycle only; reserved bits are dropped.
	always_ff @(posedge CORE_CLK or posedge RESET) begin
		if (RESET) begin
			clr_q <= FLAGS_RESET;
		end else begin
			clr_q <= clr_now; // R16
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Masked status, one gate per event bit, reserved bits tied low, built from next-state values so
	// that status and raw flags never disagree for a cycle.
	for (genvar i = 0; i < 8; i++) begin : g_mask
		if (EVENT_BITS[i]) begin : g_evt
			assign status_d[i] = raw_d[i] & en_d[i]; // R1 R6
		end else begin : g_rsv
			assign status_d[i] = 1'b0; // R14
		end
	end

	always_ff @(posedge CORE_CLK or posedge RESET) begin
		if (RESET) begin
			status_q <= FLAGS_RESET;
		end else begin
			status_q <= status_d; // R1 R2
		end
	end

	assign MASKED_STATUS = status_q;

	////////////////////////////////////////////////////////////////////////
	// Interrupt request; the hardware group joins here as one summary bit.
	always_ff @(posedge CORE_CLK or posedge RESET) begin
		if (RESET) begin
			HOST_IRQ_OUT <= !IRQ_ACTIVE_HIGH; // R19
		end else begin
			HOST_IRQ_OUT <= ((|status_d) || HW_IRQ_PENDING) ~^
				IRQ_ACTIVE_HIGH; // R3 R4 R17 R19
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read port; data appears the cycle after the read strobe.
	always_ff @(posedge CORE_CLK or posedge RESET) begin
		if (RESET) begin
			REG_RDATA <= FLAGS_RESET;
		end else if (REG_RD) begin
			unique case (REG_ADDR)
				RAW_STATUS_OFS: REG_RDATA <= raw_q;
				MASKED_STATUS_OFS: REG_RDATA <= status_q;
				ENABLE_OFS: REG_RDATA <= en_q;
				CLEAR_OFS: REG_RDATA <= clr_q;
				default: REG_RDATA <= 8'h00;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks.
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (RESET);

	logic irq_act;
	assign irq_act = HOST_IRQ_OUT == IRQ_ACTIVE_HIGH;

	sequence s_clear_write(int b);
		REG_WR && REG_ADDR == CLEAR_OFS && REG_WDATA[b] && !events[b];
	endsequence

	sequence s_short_rx;
		ANT_RX_END && ANT_RX_BIT_COUNT != 4'(RX_WORD_BITS);
	endsequence

	a_status_and_gate: assert property ( // R1
		status_q == (raw_q & en_q & EVENT_BITS))
		else $error("Masked status differs from raw AND enable.");

	a_clear_drops_flag: assert property ( // R2
		s_clear_write(TUNER_XFER_DONE_BIT) |=>
		!raw_q[TUNER_XFER_DONE_BIT] && !status_q[TUNER_XFER_DONE_BIT])
		else $error("Clear did not drop raw and status bit.");

	a_irq_or_sources: assert property ( // R4
		irq_act == ((|status_q) || $past(HW_IRQ_PENDING)))
		else $error("Interrupt request is not the OR of its sources.");

	a_masked_raw_sets: assert property ( // R5
		events[ANT_TX_COMPLETE_BIT] && !en_d[ANT_TX_COMPLETE_BIT] |=>
		raw_q[ANT_TX_COMPLETE_BIT] && !status_q[ANT_TX_COMPLETE_BIT])
		else $error("Disabled event lost its raw flag or set status.");

	a_enable_reset: assert property ( // R7
		$fell(RESET) |-> en_q == ENABLE_RESET)
		else $error("Enable bits not zero after reset.");

	a_clear_self_zero: assert property ( // R16
		(|clr_q) && !(REG_WR && REG_ADDR == CLEAR_OFS) |=> clr_q == 8'h00)
		else $error("Clear register did not return to zero.");

	a_short_rx_timeout: assert property ( // R18
		s_short_rx ##1 1'b1 |-> raw_q[ANT_RX_TIMEOUT_BIT] &&
		($past(raw_q[ANT_RX_COMPLETE_BIT]) || !raw_q[ANT_RX_COMPLETE_BIT]))
		else $error("Short receive did not raise timeout alone.");

	a_no_done_on_fail: assert property ( // R13
		TUNER_XFER_END && TUNER_XFER_FAIL && !raw_q[TUNER_XFER_DONE_BIT] |=>
		!raw_q[TUNER_XFER_DONE_BIT] && raw_q[TUNER_XFER_ERROR_BIT])
		else $error("Failed tuner transfer set done or missed error.");

	a_irq_idle_clear: assert property ( // R17
		status_q == 8'h00 && !$past(HW_IRQ_PENDING) |-> !irq_act)
		else $error("Interrupt request active with nothing pending.");

	a_reserved_quiet: assert property ( // R14
		(status_q & ~EVENT_BITS) == 8'h00 && (raw_q & ~EVENT_BITS) == 8'h00)
		else $error("Reserved status bit set.");

	// A full word is the only way into the receive-complete flag.
	sequence s_full_rx;
		ANT_RX_END && rx_full;
	endsequence

	a_full_rx_sets: assert property ( // R9
		s_full_rx |=> raw_q[ANT_RX_COMPLETE_BIT])
		else $error("Full receive word did not set its raw flag.");

	a_tx_sets_raw: assert property ( // R10
		ANT_TX_END |=> raw_q[ANT_TX_COMPLETE_BIT])
		else $error("Transmit end did not set its raw flag.");

	a_irq_follows_status: assert property ( // R3
		(|status_d) |=> irq_act)
		else $error("Set status bit did not raise the request.");

	a_enable_write: assert property ( // R7
		REG_WR && REG_ADDR == ENABLE_OFS |=> en_q == $past(REG_WDATA))
		else $error("Enable write did not land.");

endmodule

// >>> dv/host_model.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////
// Host processor on the register port. Strobes last one rising edge.
module host_model (
	input  wire logic       clk,
	input  wire logic [7:0] rdata,
	output logic      [7:0] addr,
	output logic            wr,
	output logic      [7:0] wdata,
	output logic            rd
);
	// The port idles with both strobes low.
	initial begin
		addr = 8'h00;
		wdata = 8'h00;
		wr = 1'b0;
		rd = 1'b0;
	end

	// After release, address and data flip so stale values prove nothing.
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		addr = a;
		wdata = d;
		wr = 1'b1;
		@(negedge clk);
		wr = 1'b0;
		addr = ~a;
		wdata = ~d;
	endtask

	// Read data is registered, so it is taken at the next falling edge.
	task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
		@(negedge clk);
		addr = a;
		rd = 1'b1;
		@(negedge clk);
		rd = 1'b0;
		addr = ~a;
		d = rdata;
	endtask
endmodule

// >>> dv/tb_sw_event_irq.sv
`timescale 1ns/1ps
module tb_sw_event_irq;
	import sw_event_pkg::*;
	logic       clk, rst, rx_end, rx_no, tx_end, t_end, t_fail, hw;
	logic       wr, rd, irq;
	logic [3:0] rx_cnt;
	logic [7:0] addr, wdata, rdata, mstat, v;
	int         fails = 0;
	int         total_checks = 0;

	sw_event_irq sw_event_irq_i (.CORE_CLK(clk), .RESET(rst),
		.REG_ADDR(addr), .REG_WR(wr), .REG_WDATA(wdata), .REG_RD(rd),
		.REG_RDATA(rdata), .ANT_RX_END(rx_end), .ANT_RX_BIT_COUNT(rx_cnt),
		.ANT_RX_NO_REPLY(rx_no), .ANT_TX_END(tx_end),
		.TUNER_XFER_END(t_end), .TUNER_XFER_FAIL(t_fail),
		.HW_IRQ_PENDING(hw), .HOST_IRQ_OUT(irq), .MASKED_STATUS(mstat));
	host_model host_model_i (.clk(clk), .rdata(rdata), .addr(addr),
		.wr(wr), .wdata(wdata), .rd(rd));

	////////////////////////////////////////////////////////////////////////
	// Compare and close.
	task automatic chk(input string n, input logic [7:0] e,
		input logic [7:0] g);
		total_checks++;
		if (g !== e) begin
			fails++;
			$display("CHECK FAILED %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic test_done();
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// One event pulse; s is {rx_end, rx_no, tx_end, t_end}.
	task automatic fire(input logic [3:0] s, input logic [3:0] c,
		input logic f);
		@(negedge clk);
		{rx_end, rx_no, tx_end, t_end} = s;
		rx_cnt = c;
		t_fail = f;
		@(negedge clk);
		{rx_end, rx_no, tx_end, t_end} = 4'h0;
		rx_cnt = ~c;
		t_fail = ~f;
		@(negedge clk);
	endtask

	////////////////////////////////////////////////////////////////////////
	// Scenarios.
	task automatic t_reset();
		host_model_i.rd_reg(ENABLE_OFS, v);
		chk("enable", 8'h00, v);
		host_model_i.rd_reg(MASKED_STATUS_OFS, v);
		chk("status", 8'h00, v);
		chk("irq", 8'h00, {7'h00, irq});
		$display("test reset done");
	endtask
	// A disabled event still lands in the raw flags only.
	task automatic t_masked();
		fire(4'h2, 4'h0, 1'b0);
		host_model_i.rd_reg(RAW_STATUS_OFS, v);
		chk("raw", 8'h10, v);
		chk("mstat", 8'h00, mstat);
		chk("irq", 8'h00, {7'h00, irq});
		host_model_i.wr_reg(CLEAR_OFS, 8'h10);
		host_model_i.rd_reg(RAW_STATUS_OFS, v);
		chk("raw", 8'h00, v);
		$display("test masked done");
	endtask
	// Every event, a short word too, with reserved enables set as well.
	task automatic t_events();
		logic [3:0] s [6] = '{4'h8, 4'h2, 4'h4, 4'h1, 4'h1, 4'h8};
		logic [3:0] c [6] = '{4'hA, 4'h0, 4'h0, 4'h0, 4'h0, 4'h9};
		logic       f [6] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
		logic [7:0] e [6] = '{8'h20, 8'h10, 8'h08, 8'h02,
			8'h01, 8'h08};
		host_model_i.wr_reg(ENABLE_OFS, 8'hFF);
		host_model_i.rd_reg(ENABLE_OFS, v);
		chk("enable", 8'hFF, v);
		for (int i = 0; i < 6; i++) begin
			fire(s[i], c[i], f[i]);
			chk("mstat", e[i], mstat);
			chk("irq", 8'h01, {7'h00, irq});
			host_model_i.wr_reg(CLEAR_OFS, e[i]);
			repeat (2) @(negedge clk);
			chk("mstat", 8'h00, mstat);
			chk("irq", 8'h00, {7'h00, irq});
			host_model_i.rd_reg(CLEAR_OFS, v);
			chk("clear", 8'h00, v);
		end
		$display("test events done");
	endtask
	// Partial enable, then the hardware group alone drives the request.
	task automatic t_mix();
		host_model_i.wr_reg(ENABLE_OFS, 8'h01);
		fire(4'h1, 4'h0, 1'b1);
		fire(4'h1, 4'h0, 1'b0);
		host_model_i.rd_reg(RAW_STATUS_OFS, v);
		chk("raw", 8'h03, v);
		chk("mstat", 8'h01, mstat);
		// A new done event in the clearing cycle must survive the clear.
		fork
			host_model_i.wr_reg(CLEAR_OFS, 8'h03);
			fire(4'h1, 4'h0, 1'b0);
		join
		chk("mstat", 8'h01, mstat);
		host_model_i.rd_reg(RAW_STATUS_OFS, v);
		chk("raw", 8'h01, v);
		host_model_i.wr_reg(CLEAR_OFS, 8'h01);
		hw = 1'b1;
		repeat (2) @(negedge clk);
		chk("irq", 8'h01, {7'h00, irq});
		hw = 1'b0;
		repeat (2) @(negedge clk);
		chk("irq", 8'h00, {7'h00, irq});
		host_model_i.rd_reg(8'h10, v);
		chk("unmapped", 8'h00, v);
		$display("test mix done");
	endtask

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	// A hang ends the run as a mismatch.
	initial begin
		repeat (5000) @(posedge clk);
		fails++;
		test_done();
	end
	initial begin
		{rst, rx_end, rx_no, tx_end, t_end, t_fail, hw} = 7'h40;
		rx_cnt = 4'h0;
		repeat (6) @(posedge clk);
		@(negedge clk);
		rst = 1'b0;
		t_reset();
		t_masked();
		t_events();
		t_mix();
		test_done();
	end
endmodule
